/* File: ccpt_params.svh */
// Constants for the capture compare pulse timer.
`ifndef CCPT_PARAMS_SVH
`define CCPT_PARAMS_SVH
`define CCPT_AW        8
`define CCPT_DW        16
`define CCPT_NCH       8
`define CCPT_CH7       7
`define CCPT_PW        7
`define CCPT_OFF_DIR   8'h00
`define CCPT_OFF_FRC   8'h01
`define CCPT_OFF_MSK7  8'h02
`define CCPT_OFF_DAT7  8'h03
`define CCPT_OFF_CNT   8'h04
`define CCPT_OFF_CTL1  8'h06
`define CCPT_OFF_OMOL  8'h08
`define CCPT_OFF_CEDG  8'h0a
`define CCPT_OFF_IEN   8'h0c
`define CCPT_OFF_CTL2  8'h0d
`define CCPT_OFF_CFLG  8'h0e
`define CCPT_OFF_TFLG  8'h0f
`define CCPT_OFF_VAL   8'h10
`define CCPT_OFF_PCTL  8'h20
`define CCPT_OFF_PFLG  8'h21
`define CCPT_OFF_PCNT  8'h22
`define CCPT_OFF_PORT  8'h24
`define CCPT_TMR_EN_B  7
`define CCPT_FFC_B     4
`define CCPT_CRST_B    3
`define CCPT_OVIE_B    7
`define CCPT_ACC_EN_B  6
`define CCPT_AMODE_B   5
`define CCPT_EDGE_B    4
`define CCPT_POIE_B    1
`define CCPT_PIIE_B    0
`define CCPT_POVF_B    1
`define CCPT_PINF_B    0
`define CCPT_TOVF_B    7
`define CCPT_CNT_MAX   16'hffff
`define CCPT_DIV64_M   7'h3f
`define CCPT_PS_MAX    3'h7
`endif

/* File: ccpt_pkg.sv */
// Types shared by the capture compare pulse timer.
`include "ccpt_params.svh"
package ccpt_pkg;
  typedef struct packed {
    logic [`CCPT_AW-1:0] addr;
    logic [`CCPT_DW-1:0] wdata;
    logic                wr;
    logic                rd;
  } ccpt_bus_s;
  typedef struct packed {
    logic [5:0] chan;
    logic       pulse_in;
    logic       pulse_ovf;
    logic       cnt_ovf;
  } ccpt_irq_s;
  typedef enum logic [1:0] {OC_NONE, OC_TOGGLE, OC_CLEAR, OC_SET} ccpt_oc_e;
endpackage

/* File: ccpt_pin_sync.sv */
// Pin synchroniser with edge detection for the timer pins.
`timescale 1ns/1ns
`default_nettype none
`include "ccpt_params.svh"
module ccpt_pin_sync (
  // Clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 rst_b,
  // Raw pins
  input  wire logic [`CCPT_NCH-1:0] pin_in,
  // Synchronised view
  output logic      [`CCPT_NCH-1:0] level,
  output logic      [`CCPT_NCH-1:0] rise,
  output logic      [`CCPT_NCH-1:0] fall
);
  logic [`CCPT_NCH-1:0] s1_reg;
  logic [`CCPT_NCH-1:0] s2_reg;
  logic [`CCPT_NCH-1:0] s3_reg;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  assign level = s2_reg;
  assign rise  = s2_reg & ~s3_reg;
  assign fall  = ~s2_reg & s3_reg;
endmodule
`default_nettype wire

/* File: ccpt_timer.sv */
// Capture compare pulse timer with pulse accumulator.
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
`include "ccpt_params.svh"
module ccpt_timer import ccpt_pkg::*; (
  // Clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 rst_b,
  // Register port
  input  wire ccpt_bus_s            bus_req,
  output logic      [`CCPT_DW-1:0]  rd_data,
  // Timer pins
  input  wire logic [`CCPT_NCH-1:0] pin_in,
  output logic      [`CCPT_NCH-1:0] pin_out,
  output logic      [`CCPT_NCH-1:0] pin_oe,
  // Interrupt requests
  output ccpt_irq_s                 irq
);
  ////////////////////////////////////////////////////////////////////////////
  logic [`CCPT_NCH-1:0] dir_reg;
  logic [`CCPT_NCH-1:0] msk7_reg;
  logic [`CCPT_NCH-1:0] dat7_reg;
  logic [`CCPT_DW-1:0]  cnt_reg;
  logic [7:0]           ctl1_reg;
  logic [`CCPT_DW-1:0]  omol_reg;
  logic [`CCPT_DW-1:0]  cedg_reg;
  logic [`CCPT_NCH-1:0] ien_reg;
  logic [7:0]           ctl2_reg;
  logic [`CCPT_NCH-1:0] cflg_reg;
  logic                 tovf_reg;
  logic [`CCPT_DW-1:0]  val_reg [`CCPT_NCH];
  logic [7:0]           pctl_reg;
  logic [1:0]           pflg_reg;
  logic [`CCPT_DW-1:0]  pcnt_reg;
  logic [`CCPT_NCH-1:0] port_reg;
  logic [`CCPT_NCH-1:0] oc_reg;
  logic [`CCPT_PW-1:0]  pre_reg;
  logic                 step_reg;
  logic [`CCPT_NCH-1:0] lvl;
  logic [`CCPT_NCH-1:0] rise;
  logic [`CCPT_NCH-1:0] fall;
  logic [`CCPT_NCH-1:0] hit;
  logic [`CCPT_NCH-1:0] frc;
  logic [`CCPT_NCH-1:0] cap;
  logic [`CCPT_NCH-1:0] ev;
  logic [`CCPT_NCH-1:0] cflg_clr;
  logic [1:0]           pflg_clr;
  logic [1:0]           pflg_set;
  logic                 tmr_en;
  logic                 tick;
  logic                 div64;
  logic                 acc_en;
  logic                 pa_edge;
  logic                 pa_active;
  logic                 pa_inc;
  logic                 wr_pcnt;
  logic                 acc_pcnt;

  function automatic logic [`CCPT_PW-1:0] ps_mask(input logic [2:0] sel);
    ps_mask = `CCPT_PW'((8'h01 << sel) - 8'h01);
  endfunction

  function automatic logic is_wr(input ccpt_bus_s b, input logic [`CCPT_AW-1:0] off);
    is_wr = b.wr && (b.addr == off);
  endfunction

  function automatic logic [`CCPT_AW-1:0] val_off(input int idx);
    val_off = `CCPT_OFF_VAL + `CCPT_AW'(idx * 2);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers feed capture and the accumulator.
  ccpt_pin_sync u_sync (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .pin_in   (pin_in),
    .level    (lvl),
    .rise     (rise),
    .fall     (fall)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler and main counter.
  assign tmr_en = ctl1_reg[`CCPT_TMR_EN_B];
  assign tick   = tmr_en && ((pre_reg & ps_mask(ctl2_reg[2:0])) == ps_mask(ctl2_reg[2:0]));
  assign div64  = tmr_en && ((pre_reg & `CCPT_DIV64_M) == `CCPT_DIV64_M);

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pre_reg <= '0;
    end else begin
      pre_reg <= tmr_en ? pre_reg + `CCPT_PW'(1) : '0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg  <= '0;
      step_reg <= 1'b0;
    end else begin
      step_reg <= tick;
      if (tmr_en && ctl2_reg[`CCPT_CRST_B] && hit[`CCPT_CH7]) begin
        cnt_reg <= '0;
      end else if (tick) begin
        cnt_reg <= cnt_reg + `CCPT_DW'(1);
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      tovf_reg <= 1'b0;
    end else if (tick && cnt_reg == `CCPT_CNT_MAX) begin
      tovf_reg <= 1'b1;
    end else if (is_wr(bus_req, `CCPT_OFF_TFLG) && bus_req.wdata[`CCPT_TOVF_B]) begin
      tovf_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channel events.
  always_comb begin
    for (int i = 0; i < `CCPT_NCH; i++) begin
      hit[i] = dir_reg[i] && step_reg && (cnt_reg == val_reg[i]);
      frc[i] = is_wr(bus_req, `CCPT_OFF_FRC) && bus_req.wdata[i] && dir_reg[i];
      cap[i] = !dir_reg[i] && ((cedg_reg[2*i] && rise[i]) || (cedg_reg[2*i+1] && fall[i]));
    end
  end
  assign ev       = hit | frc;
  assign cflg_clr = is_wr(bus_req, `CCPT_OFF_CFLG) ? bus_req.wdata[`CCPT_NCH-1:0] : '0;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cflg_reg <= '0;
    end else begin
      cflg_reg <= (cflg_reg & ~cflg_clr) | cap | hit;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < `CCPT_NCH; i++) begin
        val_reg[i] <= '0;
      end
    end else begin
      for (int i = 0; i < `CCPT_NCH; i++) begin
        if (cap[i]) begin
          val_reg[i] <= cnt_reg;
        end else if (is_wr(bus_req, val_off(i))) begin
          val_reg[i] <= bus_req.wdata;
        end
      end
    end
  end

  // Compare output latches, channel 7 overriding masked pins.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      oc_reg <= '0;
    end else begin
      for (int i = 0; i < `CCPT_NCH; i++) begin
        if (ev[`CCPT_CH7] && msk7_reg[i]) begin
          oc_reg[i] <= dat7_reg[i];
        end else if (ev[i]) begin
          case (ccpt_oc_e'({omol_reg[i+`CCPT_NCH], omol_reg[i]}))
            OC_TOGGLE: oc_reg[i] <= ~oc_reg[i];
            OC_CLEAR:  oc_reg[i] <= 1'b0;
            OC_SET:    oc_reg[i] <= 1'b1;
            default:   oc_reg[i] <= oc_reg[i];
          endcase
        end
      end
    end
  end

  // Disconnected pins show the port latch instead.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_out <= '0;
    end else begin
      for (int i = 0; i < `CCPT_NCH; i++) begin
        if (omol_reg[i+`CCPT_NCH] || omol_reg[i] || msk7_reg[i]) begin
          pin_out[i] <= oc_reg[i];
        end else begin
          pin_out[i] <= port_reg[i];
        end
      end
    end
  end
  assign pin_oe = dir_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Pulse accumulator.
  assign acc_en    = pctl_reg[`CCPT_ACC_EN_B];
  assign pa_edge   = pctl_reg[`CCPT_EDGE_B] ? rise[`CCPT_CH7] : fall[`CCPT_CH7];
  assign pa_active = pctl_reg[`CCPT_EDGE_B] ? !lvl[`CCPT_CH7] : lvl[`CCPT_CH7];
  assign pa_inc    = acc_en && (pctl_reg[`CCPT_AMODE_B] ? (pa_active && div64) : pa_edge);
  assign wr_pcnt   = is_wr(bus_req, `CCPT_OFF_PCNT);
  assign acc_pcnt  = (bus_req.wr || bus_req.rd) && (bus_req.addr == `CCPT_OFF_PCNT);

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pcnt_reg <= '0;
    end else if (wr_pcnt) begin
      pcnt_reg <= bus_req.wdata;
    end else if (pa_inc) begin
      pcnt_reg <= pcnt_reg + `CCPT_DW'(1);
    end
  end

  always_comb begin
    pflg_set = 2'b00;
    pflg_set[`CCPT_POVF_B] = pa_inc && !wr_pcnt && (pcnt_reg == `CCPT_CNT_MAX);
    pflg_set[`CCPT_PINF_B] = acc_en && pa_edge;
    pflg_clr = is_wr(bus_req, `CCPT_OFF_PFLG) ? bus_req.wdata[1:0] : 2'b00;
    if (ctl1_reg[`CCPT_FFC_B] && acc_pcnt) begin
      pflg_clr = 2'b11;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pflg_reg <= '0;
    end else begin
      pflg_reg <= (pflg_reg & ~pflg_clr) | pflg_set;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      dir_reg  <= '0;
      msk7_reg <= '0;
      dat7_reg <= '0;
      ctl1_reg <= '0;
      omol_reg <= '0;
      cedg_reg <= '0;
      ien_reg  <= '0;
      ctl2_reg <= '0;
      pctl_reg <= '0;
      port_reg <= '0;
    end else if (bus_req.wr) begin
      case (bus_req.addr)
        `CCPT_OFF_DIR:  dir_reg  <= bus_req.wdata[7:0];
        `CCPT_OFF_MSK7: msk7_reg <= bus_req.wdata[7:0];
        `CCPT_OFF_DAT7: dat7_reg <= bus_req.wdata[7:0];
        `CCPT_OFF_CTL1: ctl1_reg <= bus_req.wdata[7:0];
        `CCPT_OFF_OMOL: omol_reg <= bus_req.wdata;
        `CCPT_OFF_CEDG: cedg_reg <= bus_req.wdata;
        `CCPT_OFF_IEN:  ien_reg  <= bus_req.wdata[7:0];
        `CCPT_OFF_CTL2: ctl2_reg <= bus_req.wdata[7:0];
        `CCPT_OFF_PCTL: pctl_reg <= bus_req.wdata[7:0];
        `CCPT_OFF_PORT: port_reg <= bus_req.wdata[7:0];
        default:        port_reg <= port_reg;
      endcase
    end
  end

  // Read data stand in the cycle after the strobe.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_data <= '0;
    end else begin
      rd_data <= '0;
      if (bus_req.rd) begin
        case (bus_req.addr)
          `CCPT_OFF_DIR:  rd_data <= {8'h00, dir_reg};
          `CCPT_OFF_MSK7: rd_data <= {8'h00, msk7_reg};
          `CCPT_OFF_DAT7: rd_data <= {8'h00, dat7_reg};
          `CCPT_OFF_CNT:  rd_data <= cnt_reg;
          `CCPT_OFF_CTL1: rd_data <= {8'h00, ctl1_reg};
          `CCPT_OFF_OMOL: rd_data <= omol_reg;
          `CCPT_OFF_CEDG: rd_data <= cedg_reg;
          `CCPT_OFF_IEN:  rd_data <= {8'h00, ien_reg};
          `CCPT_OFF_CTL2: rd_data <= {8'h00, ctl2_reg};
          `CCPT_OFF_CFLG: rd_data <= {8'h00, cflg_reg};
          `CCPT_OFF_TFLG: rd_data <= {8'h00, tovf_reg, 7'h00};
          `CCPT_OFF_PCTL: rd_data <= {8'h00, pctl_reg};
          `CCPT_OFF_PFLG: rd_data <= {14'h0000, pflg_reg};
          `CCPT_OFF_PCNT: rd_data <= pcnt_reg;
          `CCPT_OFF_PORT: rd_data <= {8'h00, port_reg};
          default: begin
            for (int i = 0; i < `CCPT_NCH; i++) begin
              if (bus_req.addr == val_off(i)) begin
                rd_data <= val_reg[i];
              end
            end
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt requests.
  assign irq.chan      = cflg_reg[7:2] & ien_reg[7:2];
  assign irq.pulse_in  = pflg_reg[`CCPT_PINF_B] && pctl_reg[`CCPT_PIIE_B];
  assign irq.pulse_ovf = pflg_reg[`CCPT_POVF_B] && pctl_reg[`CCPT_POIE_B];
  assign irq.cnt_ovf   = tovf_reg && ctl2_reg[`CCPT_OVIE_B];

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  a_pulse_wrap_flag:
    assert property (pflg_set[`CCPT_POVF_B] |=> pflg_reg[`CCPT_POVF_B] && pcnt_reg == 16'h0000)
    else $error("pulse wrap did not set overflow flag");
  a_pulse_sync_delay:
    assert property (pa_inc && !pctl_reg[`CCPT_AMODE_B]
                     |-> $past(pin_in[`CCPT_CH7], 2) != $past(pin_in[`CCPT_CH7], 3))
    else $error("pulse edge counted without two stage delay");
  a_prescale_slowest:
    assert property (tick && ctl2_reg[2:0] == `CCPT_PS_MAX && $stable(ctl2_reg) |=> !tick [*8])
    else $error("divide by 128 ticked too soon");
  a_capture_copy:
    assert property (cap[0] |=> val_reg[0] == $past(cnt_reg))
    else $error("capture did not copy counter");
  a_flag_irq_path:
    assert property (hit[2] && ien_reg[2] |=> cflg_reg[2] && irq.chan[0])
    else $error("compare did not flag or request");
  a_cmp_toggle:
    assert property (hit[3] && omol_reg[11] == 1'b0 && omol_reg[3] && !(ev[7] && msk7_reg[3])
                     |=> oc_reg[3] != $past(oc_reg[3]))
    else $error("toggle action missing");
  a_port_latch_out:
    assert property (omol_reg[9] == 1'b0 && omol_reg[1] == 1'b0 && !msk7_reg[1]
                     |=> pin_out[1] == $past(port_reg[1]))
    else $error("disconnected pin not following port latch");
  a_force_noflag:
    assert property (frc[4] && !hit[4] && !cap[4] && !cflg_reg[4] |=> !cflg_reg[4])
    else $error("forced compare set a flag");
  a_ch7_priority:
    assert property (ev[7] && msk7_reg[5] |=> oc_reg[5] == $past(dat7_reg[5]))
    else $error("channel 7 override lost");
  a_counter_reset:
    assert property (tmr_en && ctl2_reg[`CCPT_CRST_B] && hit[7] |=> cnt_reg == 16'h0000)
    else $error("channel 7 match did not reset counter");
  a_event_count:
    assert property (acc_en && !pctl_reg[`CCPT_AMODE_B] && pa_edge && !wr_pcnt
                     |=> pcnt_reg == $past(pcnt_reg) + 16'h0001)
    else $error("event edge not counted");
  a_gated_needs_tmr:
    assert property (pctl_reg[`CCPT_AMODE_B] && !tmr_en && !wr_pcnt |=> $stable(pcnt_reg))
    else $error("gated count moved with timer off");
endmodule
`default_nettype wire

/* File: ccpt_pin_model.sv */
// External event sources and loads on the timer pins.
`timescale 1ns/1ns
`default_nettype none
`include "ccpt_params.svh"
module ccpt_pin_model (
  // Clock
  input  wire logic                 core_clk,
  // Timer pin drive
  input  wire logic [`CCPT_NCH-1:0] pin_out,
  input  wire logic [`CCPT_NCH-1:0] pin_oe,
  // Resolved pin levels
  output logic      [`CCPT_NCH-1:0] pin_level
);
  logic [`CCPT_NCH-1:0] src_reg;
  initial src_reg = '0;
  // A driving channel owns its pin, otherwise the external source sets it.
  assign pin_level = (pin_oe & pin_out) | (~pin_oe & src_reg);
  //////////////////////////////////////////////////////////////////////////////
  task automatic set_level(input int ch, input logic v);
    @(posedge core_clk);
    src_reg[ch] <= v;
  endtask
  // Pulses are never shorter than three clocks.
  task automatic pulse(input int ch, input int width);
    set_level(ch, 1'b1);
    repeat ((width < 3) ? 3 : width) @(posedge core_clk);
    src_reg[ch] <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: tb_capture_compare_pulse_timer.sv */
// Self-checking testbench for the capture compare pulse timer.
`timescale 1ns/1ns
`default_nettype none
`include "ccpt_params.svh"
`define TB_CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; \
  $display("mismatch %s expected %h seen %h", nm, e, g); end end
module tb_capture_compare_pulse_timer import ccpt_pkg::*;;
  logic                 core_clk;
  logic                 rst_b;
  ccpt_bus_s            bus_req;
  logic [`CCPT_DW-1:0]  rd_data;
  logic [`CCPT_NCH-1:0] pin_in;
  logic [`CCPT_NCH-1:0] pin_out;
  logic [`CCPT_NCH-1:0] pin_oe;
  ccpt_irq_s            irq;
  int                   n_mismatch;
  int                   checks_done;
  int                   cyc;
  int                   k;
  logic [15:0]          a;
  logic [15:0]          b;
  logic [15:0]          v;
  logic                 pin_exp;
  logic [1:0]           ml_tab [4];
  //////////////////////////////////////////////////////////////////////////////
  ccpt_timer u_dut (.core_clk(core_clk), .rst_b(rst_b), .bus_req(bus_req),
    .rd_data(rd_data), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .irq(irq));
  ccpt_pin_model u_pins (.core_clk(core_clk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_level(pin_in));
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 100000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] exp_steps(input int ps);
    return 16'(256 >> ps);
  endfunction
  function automatic logic oc_pin(input logic [1:0] ml, input logic prev);
    case (ml)
      2'b01: return ~prev;
      2'b10: return 1'b0;
      2'b11: return 1'b1;
      default: return prev;
    endcase
  endfunction
  task automatic wr(input logic [7:0] ad, input logic [15:0] d);
    @(posedge core_clk);
    bus_req.addr <= ad;
    bus_req.wdata <= d;
    bus_req.wr <= 1'b1;
    @(posedge core_clk);
    bus_req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad, output logic [15:0] d);
    @(posedge core_clk);
    bus_req.addr <= ad;
    bus_req.rd <= 1'b1;
    @(posedge core_clk);
    bus_req.rd <= 1'b0;
    #1 d = rd_data;
  endtask
  task automatic rd_chk(input string nm, input logic [7:0] ad, input logic [15:0] e);
    logic [15:0] got;
    rd(ad, got);
    `TB_CHK(nm, e, got)
  endtask
  task automatic wrap_up();
    if (n_mismatch == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_b = 1'b0;
    bus_req = '0;
    n_mismatch = 0;
    checks_done = 0;
    cyc = 0;
    ml_tab = '{2'b11, 2'b10, 2'b01, 2'b01};
    void'($urandom(17087));
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    rd_chk("ctl_one", `CCPT_OFF_CTL1, 16'h0000);
    wr(8'h30, 16'hffff);
    rd_chk("unmapped", 8'h30, 16'h0000);
    rd_chk("force_rd", `CCPT_OFF_FRC, 16'h0000);
    // Prescaler steps and counter overflow.
    wr(`CCPT_OFF_CTL1, 16'h0080);
    for (int ps = 0; ps < 8; ps++) begin
      wr(`CCPT_OFF_CTL2, 16'(ps));
      repeat (256) @(posedge core_clk);
      rd(`CCPT_OFF_CNT, a);
      repeat (254) @(posedge core_clk);
      rd(`CCPT_OFF_CNT, b);
      `TB_CHK("count_step", exp_steps(ps), 16'(b - a))
    end
    wr(`CCPT_OFF_CTL2, 16'h0080);
    wr(`CCPT_OFF_TFLG, 16'h0080);
    rd(`CCPT_OFF_CNT, a);
    repeat (65576 - int'(a)) @(posedge core_clk);
    rd_chk("ovf_flag", `CCPT_OFF_TFLG, 16'h0080);
    `TB_CHK("irq_ovf", 1'b1, irq.cnt_ovf)
    wr(`CCPT_OFF_TFLG, 16'h0080);
    #1 `TB_CHK("irq_ovf_clr", 1'b0, irq.cnt_ovf)
    // Forced compare actions on channel 2 with the timer stopped.
    wr(`CCPT_OFF_CTL1, 16'h0000);
    wr(`CCPT_OFF_CTL2, 16'h0000);
    wr(`CCPT_OFF_DIR, 16'h0004);
    pin_exp = 1'b0;
    for (int i = 0; i < 4; i++) begin
      wr(`CCPT_OFF_OMOL, (16'(ml_tab[i][1]) << 10) | (16'(ml_tab[i][0]) << 2));
      wr(`CCPT_OFF_FRC, 16'h0004);
      pin_exp = oc_pin(ml_tab[i], pin_exp);
      repeat (3) @(posedge core_clk);
      #1 `TB_CHK("oc_pin", pin_exp, pin_out[2])
    end
    wr(`CCPT_OFF_PORT, 16'h0004);
    repeat (3) @(posedge core_clk);
    #1 `TB_CHK("port_hidden", 1'b0, pin_out[2])
    wr(`CCPT_OFF_OMOL, 16'h0000);
    repeat (3) @(posedge core_clk);
    #1 `TB_CHK("port_shown", 1'b1, pin_out[2])
    `TB_CHK("pin_drive", 1'b1, pin_oe[2])
    rd_chk("force_noflag", `CCPT_OFF_CFLG, 16'h0000);
    // Channel 7 wraps the counter and drives pin 3 through its mask.
    wr(`CCPT_OFF_DIR, 16'h008c);
    wr(`CCPT_OFF_VAL + 8'd14, 16'h00ff);
    wr(`CCPT_OFF_VAL + 8'd4, 16'($urandom_range(1, 254)));
    wr(`CCPT_OFF_MSK7, 16'h0008);
    wr(`CCPT_OFF_DAT7, 16'h0008);
    wr(`CCPT_OFF_IEN, 16'h0004);
    wr(`CCPT_OFF_CTL2, 16'h0008);
    wr(`CCPT_OFF_CTL1, 16'h0080);
    repeat (300) @(posedge core_clk);
    rd(`CCPT_OFF_CFLG, v);
    `TB_CHK("match_flags", 16'h0084, v & 16'h0084)
    `TB_CHK("irq_ch2", 6'h01, irq.chan)
    `TB_CHK("mask_pin", 1'b1, pin_out[3])
    for (int i = 0; i < 4; i++) begin
      repeat ($urandom_range(1, 40)) @(posedge core_clk);
      rd(`CCPT_OFF_CNT, a);
      `TB_CHK("count_wrap", 1'b1, a <= 16'h00ff)
    end
    wr(`CCPT_OFF_DAT7, 16'h0000);
    repeat (300) @(posedge core_clk);
    `TB_CHK("mask_pin_lo", 1'b0, pin_out[3])
    wr(`CCPT_OFF_CFLG, 16'h00ff);
    // Capture on channel 0.
    wr(`CCPT_OFF_CTL2, 16'h000f);
    wr(`CCPT_OFF_CEDG, 16'h0001);
    rd(`CCPT_OFF_CNT, a);
    u_pins.pulse(0, $urandom_range(3, 8));
    repeat (4) @(posedge core_clk);
    rd(`CCPT_OFF_VAL, v);
    rd(`CCPT_OFF_CNT, b);
    `TB_CHK("capture", 1'b1, (v === a) || (v === b))
    rd(`CCPT_OFF_CFLG, v);
    `TB_CHK("cap_flag", 16'h0001, v & 16'h0001)
    // Event counting with the timer stopped.
    wr(`CCPT_OFF_CTL1, 16'h0000);
    wr(`CCPT_OFF_CTL2, 16'h0000);
    wr(`CCPT_OFF_DIR, 16'h000c);
    wr(`CCPT_OFF_MSK7, 16'h0000);
    k = $urandom_range(1, 4);
    wr(`CCPT_OFF_PCNT, 16'(17'h1_0000 - k));
    wr(`CCPT_OFF_PCTL, 16'h0052);
    u_pins.set_level(7, 1'b1);
    rd_chk("count_sync", `CCPT_OFF_PCNT, 16'(17'h1_0000 - k));
    repeat (4) @(posedge core_clk);
    u_pins.set_level(7, 1'b0);
    for (int i = 1; i < k; i++) begin
      repeat (4) @(posedge core_clk);
      u_pins.pulse(7, $urandom_range(3, 8));
    end
    repeat (6) @(posedge core_clk);
    rd_chk("pcount_wrap", `CCPT_OFF_PCNT, 16'h0000);
    rd_chk("pflags", `CCPT_OFF_PFLG, 16'h0003);
    `TB_CHK("irq_povf", 1'b1, irq.pulse_ovf)
    wr(`CCPT_OFF_PFLG, 16'h0002);
    rd_chk("pflag_w1c", `CCPT_OFF_PFLG, 16'h0001);
    `TB_CHK("irq_povf_clr", 1'b0, irq.pulse_ovf)
    wr(`CCPT_OFF_CTL1, 16'h0010);
    rd_chk("fast_clr_cnt", `CCPT_OFF_PCNT, 16'h0000);
    rd_chk("fast_clr", `CCPT_OFF_PFLG, 16'h0000);
    wr(`CCPT_OFF_PCTL, 16'h0040);
    u_pins.set_level(7, 1'b1);
    repeat (8) @(posedge core_clk);
    rd_chk("fall_only", `CCPT_OFF_PCNT, 16'h0000);
    u_pins.set_level(7, 1'b0);
    repeat (8) @(posedge core_clk);
    rd_chk("fall_count", `CCPT_OFF_PCNT, 16'h0001);
    wr(`CCPT_OFF_PCTL, 16'h0000);
    u_pins.pulse(7, 5);
    repeat (8) @(posedge core_clk);
    rd_chk("acc_off", `CCPT_OFF_PCNT, 16'h0001);
    // Gated accumulation.
    wr(`CCPT_OFF_CTL1, 16'h0000);
    wr(`CCPT_OFF_PCTL, 16'h0061);
    wr(`CCPT_OFF_PCNT, 16'h0000);
    u_pins.set_level(7, 1'b1);
    repeat (200) @(posedge core_clk);
    rd_chk("gate_no_clk", `CCPT_OFF_PCNT, 16'h0000);
    u_pins.set_level(7, 1'b0);
    repeat (6) @(posedge core_clk);
    wr(`CCPT_OFF_PFLG, 16'h0003);
    wr(`CCPT_OFF_CTL1, 16'h0080);
    repeat (10) @(posedge core_clk);
    u_pins.set_level(7, 1'b1);
    repeat (319) @(posedge core_clk);
    u_pins.set_level(7, 1'b0);
    repeat (8) @(posedge core_clk);
    rd_chk("gate_count", `CCPT_OFF_PCNT, 16'h0005);
    rd_chk("gate_flag", `CCPT_OFF_PFLG, 16'h0001);
    `TB_CHK("irq_pin", 1'b1, irq.pulse_in)
    wrap_up();
  end
endmodule
`default_nettype wire
